// *** verilog/baud_pkg.sv ***
package baud_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_CTRL_ADDR = 8'h00;
  localparam logic [7:0] RX_CTRL_ADDR = 8'h04;
  localparam logic [7:0] BAUD_CTRL_ADDR = 8'h08;
  localparam logic [7:0] DIV_HIGH_ADDR = 8'h0C;
  localparam logic [7:0] DIV_LOW_ADDR = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int PORT_ENABLE_BIT = 7;
  localparam int WIDE_DIV_BIT = 3;
  localparam int RESERVED_HI_BIT = 5;
  localparam int RESERVED_LO_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values, writable masks, read-only ones
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_CTRL_RESET = 8'h00;
  localparam logic [7:0] RX_CTRL_RESET = 8'h00;
  localparam logic [7:0] BAUD_CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] TX_CTRL_WMASK = 8'hFD;
  localparam logic [7:0] RX_CTRL_WMASK = 8'hF8;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h9B;
  localparam logic [7:0] TX_CTRL_ONES = 8'h02;
  localparam logic [7:0] BAUD_CTRL_ONES = 8'h40;

  // ----------------------------------------------------------------
  // Rate multipliers and sampler
  // ----------------------------------------------------------------
  localparam logic [6:0] MULT_LOW_SPEED = 7'h40;
  localparam logic [6:0] MULT_HIGH_SPEED = 7'h10;
  localparam logic [6:0] MULT_SYNC = 7'h04;
  localparam logic [2:0] SAMPLE_RESET = 3'h7;

  typedef struct packed {
    logic enable;
    logic sync;
    logic wide;
    logic high_speed;
  } mode_t;

  typedef enum {TIMER_IDLE, TIMER_LOAD, TIMER_RUN} timer_state_t;

endpackage : baud_pkg

// *** verilog/majority_sampler.sv ***
`timescale 1ns/100ps
module majority_sampler import baud_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clear_i,
  input wire logic strobe_i,
  input wire logic rx_i,
  output logic level_o
);

  logic [2:0] samples_reg;
  logic [2:0] samples_next;
  logic level_reg;
  wire logic vote;

  // --------------------------------------------------------------
  // Three-sample vote
  // --------------------------------------------------------------
  assign samples_next = clear_i ? SAMPLE_RESET :
                        strobe_i ? {samples_reg[1:0], rx_i} : samples_reg;
  assign vote = (samples_reg[0] & samples_reg[1]) |
                (samples_reg[1] & samples_reg[2]) |
                (samples_reg[0] & samples_reg[2]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      samples_reg <= SAMPLE_RESET;
      level_reg <= 1'b1;
    end else if (ce_i) begin
      samples_reg <= samples_next;
      level_reg <= vote;
    end
  end

  assign level_o = level_reg;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  majority_vote_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i |=> level_o == (($past(samples_reg) == 3'h3) ||
      ($past(samples_reg) == 3'h5) || ($past(samples_reg) == 3'h6) ||
      ($past(samples_reg) == 3'h7)))
    else $error("vote does not follow sample majority");

  sample_shift_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && strobe_i && !clear_i |=> samples_reg[0] == $past(rx_i))
    else $error("sample not taken on strobe");

endmodule : majority_sampler

// *** verilog/serial_baud_rate_generator.sv ***
`timescale 1ns/100ps
module serial_baud_rate_generator import baud_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic rx_i,
  output logic rx_level_o,
  output logic rate_tick_o,
  output logic bit_tick_o,
  output logic port_enable_o,
  output logic sync_mode_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [7:0] tx_ctrl_reg;
  logic [7:0] rx_ctrl_reg;
  logic [7:0] baud_ctrl_reg;
  logic [7:0] div_high_reg;
  logic [7:0] div_low_reg;
  logic [7:0] tx_ctrl_next;
  logic [7:0] rx_ctrl_next;
  logic [7:0] baud_ctrl_next;
  logic [7:0] div_high_next;
  logic [7:0] div_low_next;
  timer_state_t state_reg;
  timer_state_t state_next;
  logic [15:0] timer_reg;
  logic [15:0] timer_next;
  logic [6:0] presc_reg;
  logic [6:0] presc_next;
  logic rate_tick_reg;
  logic rate_tick_next;
  logic bit_tick_reg;
  logic bit_tick_next;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  wire logic bus_req;
  wire logic bus_take;
  wire logic bus_write;
  wire logic hit_tx;
  wire logic hit_rx;
  wire logic hit_baud;
  wire logic hit_high;
  wire logic hit_low;
  wire logic [7:0] read_byte;
  wire logic div_write;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // Answer one cycle after the request; the write lands on the ack edge
  assign bus_take = bus_req & ~ack_reg;
  assign bus_write = bus_req & ack_reg & wb_we_i & wb_sel_i[0];
  assign hit_tx = wb_adr_i == TX_CTRL_ADDR;
  assign hit_rx = wb_adr_i == RX_CTRL_ADDR;
  assign hit_baud = wb_adr_i == BAUD_CTRL_ADDR;
  assign hit_high = wb_adr_i == DIV_HIGH_ADDR;
  assign hit_low = wb_adr_i == DIV_LOW_ADDR;

  // Unmapped addresses still ack, reading zero
  assign read_byte = hit_tx ? (tx_ctrl_reg | TX_CTRL_ONES) :
                     hit_rx ? rx_ctrl_reg :
                     hit_baud ? (baud_ctrl_reg | BAUD_CTRL_ONES) :
                     hit_high ? div_high_reg :
                     hit_low ? div_low_reg : 8'h00;

  assign tx_ctrl_next = (bus_write && hit_tx) ?
                        (wb_dat_i[7:0] & TX_CTRL_WMASK) : tx_ctrl_reg;
  assign rx_ctrl_next = (bus_write && hit_rx) ?
                        (wb_dat_i[7:0] & RX_CTRL_WMASK) : rx_ctrl_reg;
  assign baud_ctrl_next = (bus_write && hit_baud) ?
                          (wb_dat_i[7:0] & BAUD_CTRL_WMASK) :
                          baud_ctrl_reg;
  assign div_high_next = (bus_write && hit_high) ? wb_dat_i[7:0] :
                         div_high_reg;
  assign div_low_next = (bus_write && hit_low) ? wb_dat_i[7:0] :
                        div_low_reg;
  assign div_write = bus_write & (hit_high | hit_low);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
      tx_ctrl_reg <= TX_CTRL_RESET;
      rx_ctrl_reg <= RX_CTRL_RESET;
      baud_ctrl_reg <= BAUD_CTRL_RESET;
      div_high_reg <= DIV_RESET;
      div_low_reg <= DIV_RESET;
    end else if (ce_i) begin
      ack_reg <= bus_take;
      if (bus_take) begin
        dat_reg <= {24'h00_0000, read_byte};
      end
      tx_ctrl_reg <= tx_ctrl_next;
      rx_ctrl_reg <= rx_ctrl_next;
      baud_ctrl_reg <= baud_ctrl_next;
      div_high_reg <= div_high_next;
      div_low_reg <= div_low_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode and divisor selection
  // ----------------------------------------------------------------
  mode_t mode;
  wire logic [15:0] div_eff;
  wire logic [6:0] mult;
  wire logic [6:0] mult_last;

  assign mode.enable = rx_ctrl_reg[PORT_ENABLE_BIT];
  assign mode.sync = tx_ctrl_reg[SYNC_BIT];
  assign mode.wide = baud_ctrl_reg[WIDE_DIV_BIT];
  assign mode.high_speed = tx_ctrl_reg[HIGH_SPEED_BIT];

  // Narrow mode ignores the high byte, except that writing it restarts the timer
  assign div_eff = mode.wide ? {div_high_reg, div_low_reg} :
                   {8'h00, div_low_reg};

  assign mult = mode.sync ? MULT_SYNC :
                (mode.wide & mode.high_speed) ? MULT_SYNC :
                (mode.wide ^ mode.high_speed) ? MULT_HIGH_SPEED :
                MULT_LOW_SPEED;
  assign mult_last = mult - 7'h01;

  // ----------------------------------------------------------------
  // Divisor timer
  // ----------------------------------------------------------------
  // One decrement per enabled device clock, so a clock switch
  // moves the rate with it until software reloads the divisor.
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    presc_next = presc_reg;
    rate_tick_next = 1'b0;
    bit_tick_next = 1'b0;
    case (state_reg)
      TIMER_IDLE: begin
        timer_next = 16'h0000;
        presc_next = 7'h00;
        state_next = TIMER_LOAD;
      end
      TIMER_LOAD: begin
        timer_next = div_eff;
        presc_next = 7'h00;
        state_next = TIMER_RUN;
      end
      TIMER_RUN: begin
        if (timer_reg == 16'h0000) begin
          timer_next = div_eff;
          rate_tick_next = 1'b1;
          // Mode change mid-bit: a prescaler past the new limit wraps
          if (presc_reg >= mult_last) begin
            presc_next = 7'h00;
            bit_tick_next = 1'b1;
          end else begin
            presc_next = presc_reg + 7'h01;
          end
        end else begin
          timer_next = timer_reg - 16'h0001;
        end
      end
      default: begin
        state_next = TIMER_IDLE;
      end
    endcase
    if (div_write) begin
      state_next = TIMER_LOAD;
      rate_tick_next = 1'b0;
      bit_tick_next = 1'b0;
    end
    if (!mode.enable) begin
      state_next = TIMER_IDLE;
      timer_next = 16'h0000;
      presc_next = 7'h00;
      rate_tick_next = 1'b0;
      bit_tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= TIMER_IDLE;
      timer_reg <= 16'h0000;
      presc_reg <= 7'h00;
      rate_tick_reg <= 1'b0;
      bit_tick_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      presc_reg <= presc_next;
      rate_tick_reg <= rate_tick_next;
      bit_tick_reg <= bit_tick_next;
    end
  end

  // ----------------------------------------------------------------
  // Receive line sampling
  // ----------------------------------------------------------------
  majority_sampler u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clear_i(~mode.enable),
    .strobe_i(rate_tick_reg),
    .rx_i(rx_i),
    .level_o(rx_level_o)
  );

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign rate_tick_o = rate_tick_reg;
  assign bit_tick_o = bit_tick_reg;
  assign port_enable_o = rx_ctrl_reg[PORT_ENABLE_BIT];
  assign sync_mode_o = tx_ctrl_reg[SYNC_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  mult_low_a: assert property (
    !mode.sync && !mode.wide && !mode.high_speed |-> mult == 7'h40)
    else $error("low speed multiplier is not 64");

  mult_mid_a: assert property (
    !mode.sync && (mode.wide != mode.high_speed) |-> mult == 7'h10)
    else $error("high speed multiplier is not 16");

  mult_sync_a: assert property (
    mode.sync |-> mult == 7'h04)
    else $error("sync multiplier is not 4");

  mult_both_a: assert property (
    !mode.sync && mode.wide && mode.high_speed |-> mult == 7'h04)
    else $error("wide high speed multiplier is not 4");

  narrow_div_a: assert property (
    !mode.wide |-> div_eff[15:8] == 8'h00 &&
      div_eff[7:0] == div_low_reg)
    else $error("narrow divisor uses the high byte");

  timer_step_a: assert property (
    ce_i && mode.enable && !div_write && state_reg == TIMER_RUN &&
      timer_reg != 16'h0000 |=>
      timer_reg == $past(timer_reg) - 16'h0001 && !rate_tick_o)
    else $error("timer did not step by one");

  reload_tick_a: assert property (
    ce_i && mode.enable && !div_write && state_reg == TIMER_RUN &&
      timer_reg == 16'h0000 |=>
      rate_tick_o && timer_reg == $past(div_eff))
    else $error("timer did not reload with a tick");

  bit_tick_a: assert property (
    ce_i && mode.enable && !div_write && state_reg == TIMER_RUN &&
      timer_reg == 16'h0000 && presc_reg == mult_last |=>
      bit_tick_o && presc_reg == 7'h00)
    else $error("bit tick missed at prescaler end");

  div_clear_a: assert property (
    ce_i && div_write && mode.enable ##1 ce_i && mode.enable |=>
      state_reg == TIMER_RUN && timer_reg == $past(div_eff))
    else $error("divisor write did not restart the timer");

  hold_reset_a: assert property (
    ce_i && !mode.enable |=> timer_reg == 16'h0000 &&
      !rate_tick_o && !bit_tick_o && presc_reg == 7'h00)
    else $error("timer runs while port disabled");

  reserved_read_a: assert property (
    wb_ack_o && hit_baud && bus_req |->
      wb_dat_o[RESERVED_HI_BIT] == 1'b0 &&
      wb_dat_o[RESERVED_LO_BIT] == 1'b0)
    else $error("reserved baud control bit reads one");

  ack_one_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  tick_seen_c: cover property (rate_tick_o ##1 !rate_tick_o);
  bit_low_c: cover property (
    bit_tick_o && mult == 7'h40 && !mode.wide);
  bit_sync_c: cover property (bit_tick_o && mode.sync && mode.wide);
  div_restart_c: cover property (
    div_write && state_reg == TIMER_RUN && timer_reg != 16'h0000);

endmodule : serial_baud_rate_generator

// *** sim/serial_line_model.sv ***
`timescale 1ns/100ps
module serial_line_model #(
  parameter int BIT_CYCLES = 5
) (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  output logic rx_o
);
  // ----------------------------------------------------------------
  // Remote async transmitter: start, 8 data lsb first, stop
  // ----------------------------------------------------------------
  // Line rests at mark level between frames
  logic [9:0] frame_reg = 10'h3FF;
  logic busy_reg = 1'b0;
  logic line_reg = 1'b1;
  int bits_left = 0;
  int cnt = 0;

  assign busy_o = busy_reg;
  assign rx_o = line_reg;
  always @(posedge clk_i) begin
    if (!busy_reg) begin
      if (send_i) begin
        busy_reg <= 1'b1;
        frame_reg <= {1'b1, data_i, 1'b0};
        bits_left <= 10;
        cnt <= 0;
      end
    end else begin
      if (cnt == 0) begin
        line_reg <= frame_reg[0];
        frame_reg <= {1'b1, frame_reg[9:1]};
        bits_left <= bits_left - 1;
      end
      cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
      if (cnt == BIT_CYCLES - 1 && bits_left == 0) busy_reg <= 1'b0;
    end
  end
endmodule : serial_line_model

// *** sim/serial_baud_rate_generator_bench.sv ***
`timescale 1ns/100ps
module serial_baud_rate_generator_bench import baud_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic send = 1'b0;
  logic [7:0] sdata = 8'h00;
  logic ack, lvl, rtick, btick, pen, smode, rx, busy;
  logic [31:0] dout;
  logic [2:0] hist = 3'h7;
  logic mon_on = 1'b0;
  logic [31:0] seed = 32'h0000E71B;
  logic ce = 1'b1;
  logic slow = 1'b0;
  int num_errors = 0;
  int n_compared = 0;

  serial_baud_rate_generator dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(dout), .rx_i(rx), .rx_level_o(lvl), .rate_tick_o(rtick),
    .bit_tick_o(btick), .port_enable_o(pen), .sync_mode_o(smode));
  serial_line_model #(.BIT_CYCLES(5)) far (.clk_i(clk_i), .send_i(send),
    .data_i(sdata), .busy_o(busy), .rx_o(rx));

  initial forever #5 clk_i = ~clk_i;

  // Alternate enables stand in for a half-speed device clock
  always @(posedge clk_i) ce <= slow ? ~ce : 1'b1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic int mult_of(input logic s, input logic w,
                                 input logic h);
    if (s || (w && h)) return 4;
    return (w || h) ? 16 : 64;
  endfunction : mult_of
  function automatic logic maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction : maj
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      check(32'h0, 32'h1);
      conclude();
    end
    @(posedge clk_i);
    q = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h0, e});
  endtask : rc
  task automatic wait_tick(output int i);
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (btick !== 1'b1 && i < 20000);
    if (i >= 20000) begin
      check(32'h0, 32'h1);
      conclude();
    end
  endtask : wait_tick
  task automatic rate_chk(input int n, input int m);
    int i, r;
    wait_tick(i);
    r = 0;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
      if (rtick === 1'b1) r++;
    end while (btick !== 1'b1 && i < 20000);
    check(i, m * (n + 1));
    check(r, m);
  endtask : rate_chk
  // Rise to rise of the bit tick; ticks stretch while enables alternate
  task automatic period(output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (btick !== 1'b0 && n < 8);
    wait_tick(n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (btick === 1'b1 && n < 8);
    do begin
      @(negedge clk_i);
      n++;
    end while (btick !== 1'b1 && n < 20000);
  endtask : period

  always @(negedge clk_i) begin
    if (mon_on && rtick === 1'b1) begin
      check({31'h0, lvl}, {31'h0, maj(hist)});
      hist = {hist[1:0], rx};
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] lo;
    int i;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(TX_CTRL_ADDR, TX_CTRL_ONES);
    rc(RX_CTRL_ADDR, 8'h00);
    rc(BAUD_CTRL_ADDR, BAUD_CTRL_ONES);
    rc(DIV_HIGH_ADDR, 8'h00);
    rc(DIV_LOW_ADDR, 8'h00);
    wr(BAUD_CTRL_ADDR, 8'hFF);
    rc(BAUD_CTRL_ADDR, 8'hDB);
    wr(8'h14, 8'hFF);
    rc(8'h14, 8'h00);
    sel <= 4'hE;
    wr(DIV_LOW_ADDR, 8'h55);
    sel <= 4'hF;
    rc(DIV_LOW_ADDR, 8'h00);
    $display("register test done");
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      lo = {5'h00, seed[2:0]} | 8'h01;
      wr(RX_CTRL_ADDR, 8'h00);
      wr(TX_CTRL_ADDR, {3'h0, k[2], 1'b0, k[0], 2'h0});
      wr(BAUD_CTRL_ADDR, {4'h0, k[1], 3'h0});
      wr(DIV_HIGH_ADDR, 8'h01);
      wr(DIV_LOW_ADDR, lo);
      wr(RX_CTRL_ADDR, 8'h80);
      // Narrow modes must ignore the nonzero high byte
      rate_chk(k[1] ? 256 + lo : lo, mult_of(k[2], k[1], k[0]));
      check({31'h0, pen}, 32'h1);
      check({31'h0, smode}, {31'h0, k[2]});
      $display("rate mode %0d done", k);
    end
    wr(RX_CTRL_ADDR, 8'h00);
    wr(TX_CTRL_ADDR, 8'h10);
    wr(BAUD_CTRL_ADDR, 8'h00);
    wr(DIV_LOW_ADDR, 8'h01);
    hist = 3'h7;
    mon_on = 1'b1;
    wr(RX_CTRL_ADDR, 8'h80);
    repeat (6) begin
      @(posedge clk_i);
      seed = xs(seed);
      sdata <= seed[7:0];
      send <= 1'b1;
      @(posedge clk_i);
      send <= 1'b0;
      i = 0;
      do begin
        @(negedge clk_i);
        i++;
      end while (busy !== 1'b0 && i < 200);
      check({31'h0, busy}, 32'h0);
    end
    mon_on = 1'b0;
    $display("sampler test done");
    wr(RX_CTRL_ADDR, 8'h00);
    wr(DIV_LOW_ADDR, 8'hFF);
    wr(RX_CTRL_ADDR, 8'h80);
    repeat (30) @(posedge clk_i);
    // Old count of 255 is far from expiry here
    wr(DIV_LOW_ADDR, 8'h02);
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (rtick !== 1'b1 && i < 600);
    check(i, 5);
    $display("restart test done");
    // Slower device clock stretches the bit until software reloads
    wr(DIV_LOW_ADDR, 8'h03);
    slow <= 1'b1;
    period(i);
    check(i, 2 * mult_of(1'b1, 1'b0, 1'b0) * (3 + 1));
    slow <= 1'b0;
    wr(DIV_LOW_ADDR, 8'h01);
    slow <= 1'b1;
    period(i);
    check(i, mult_of(1'b1, 1'b0, 1'b0) * (3 + 1));
    slow <= 1'b0;
    $display("clock scaling test done");
    wr(RX_CTRL_ADDR, 8'h00);
    repeat (2) @(posedge clk_i);
    i = 0;
    repeat (400) begin
      @(negedge clk_i);
      if (rtick !== 1'b0 || btick !== 1'b0) i++;
    end
    check(i, 0);
    check({31'h0, pen}, 32'h0);
    check({31'h0, lvl}, 32'h1);
    $display("disable test done");
    wr(DIV_HIGH_ADDR, 8'h5A);
    wr(RX_CTRL_ADDR, 8'h80);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(RX_CTRL_ADDR, RX_CTRL_RESET);
    rc(DIV_HIGH_ADDR, DIV_RESET);
    rc(BAUD_CTRL_ADDR, BAUD_CTRL_RESET | BAUD_CTRL_ONES);
    check({31'h0, rtick}, 32'h0);
    check({31'h0, lvl}, 32'h1);
    $display("reset test done");
    conclude();
  end
endmodule : serial_baud_rate_generator_bench
